// ==== verilog/opdec_pkg.sv ====
// Package: decode classes, operand and timing constants for the decoder
package opdec_pkg;

    // Operation classes produced by the decoder
    typedef enum logic [5:0] {
        OP_ILLEGAL, OP_ADD, OP_ADD_WITH_CARRY, OP_LOGICAL_AND_OP,
        OP_LOGICAL_OR_OP, OP_EXCLUSIVE_OR_OP, OP_INC_A, OP_DEC_A, OP_CLR_A,
        OP_CPL_A, OP_DECIMAL_ADJUST, OP_NIBBLE_SWAP, OP_ROTATE_LEFT,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_CARRY,
        OP_PORT_INPUT, OP_PORT_OUTPUT, OP_EXPANDER_READ, OP_EXPANDER_WRITE,
        OP_EXPANDER_AND, OP_EXPANDER_OR, OP_INC_OPERAND,
        OP_DECREMENT_BRANCH_NONZERO, OP_BRANCH, OP_CALL, OP_MOVE_TO_A,
        OP_MOVE_FROM_A, OP_MOVE_IMMEDIATE, OP_SWAP_WITH_REGISTER,
        OP_SWAP_LOW_NIBBLE, OP_PAGE_FETCH, OP_CONVERTER_RESULT_READ,
        OP_SELECT_ANALOG_ZERO, OP_SELECT_ANALOG_ONE, OP_EXT_INT_ENABLE,
        OP_EXT_INT_DISABLE, OP_TIMER_INTERRUPT_ENABLE,
        OP_TIMER_INTERRUPT_DISABLE, OP_INTERRUPT_EXIT, OP_SUBROUTINE_EXIT
    } op_class_t;

    // Operand source selection
    typedef enum logic [1:0] {
        SRC_NONE, SRC_REGISTER, SRC_INDIRECT, SRC_IMMEDIATE
    } operand_src_t;

    // Branch conditions
    typedef enum logic [3:0] {
        COND_ALWAYS, COND_CARRY_SET, COND_CARRY_CLEAR, COND_ACC_ZERO,
        COND_ACC_NONZERO, COND_TEST_ONE_HIGH, COND_TEST_ONE_LOW,
        COND_TEST_ZERO_HIGH, COND_TEST_ZERO_LOW, COND_TIMER_FLAG,
        COND_REG_NONZERO
    } branch_cond_t;

    // Decoded instruction word handed to the datapath
    typedef struct packed {
        op_class_t    op_class;
        operand_src_t operand_src;
        branch_cond_t branch_cond;
        logic [2:0]   working_register_index;
        logic         pointer_index;
        logic [1:0]   port_select;
        logic [2:0]   call_page;
        logic [1:0]   byte_count;
        logic [1:0]   cycle_count;
        logic         legal;
    } decode_t;

    // Field positions in the opcode
    localparam int REG_LSB       = 0;
    localparam int REG_MSB       = 2;
    localparam int CALL_PAGE_LSB = 5;
    localparam int CALL_PAGE_MSB = 7;
    localparam logic [3:0] CALL_LOW_NIBBLE = 4'h4;

    // Byte and cycle counts
    localparam logic [1:0] ONE_BYTE   = 2'h1;
    localparam logic [1:0] TWO_BYTES  = 2'h2;
    localparam logic [1:0] ONE_CYCLE  = 2'h1;
    localparam logic [1:0] TWO_CYCLES = 2'h2;

    // Reset value of the opcode holding register
    localparam logic [7:0] OPCODE_RESET = 8'h00;

endpackage

// ==== verilog/opcode_table.sv ====
// Combinational opcode table: one byte in, decoded fields out
`timescale 1ns/1ns
`default_nettype none
module opcode_table (
    // Opcode byte
    input  wire logic [7:0]       opcode_in,
    // Decoded fields
    output opdec_pkg::decode_t    decode_out
);

    // Fill in a decode entry from class, source, length and timing
    function automatic opdec_pkg::decode_t entry(
        input logic [7:0]            op,
        input opdec_pkg::op_class_t  cls,
        input opdec_pkg::operand_src_t src,
        input logic [1:0]            bytes,
        input logic [1:0]            cycles
    );
        opdec_pkg::decode_t d;
        d = '0;
        d.op_class               = cls;
        d.operand_src            = src;
        d.branch_cond            = opdec_pkg::COND_ALWAYS;
        d.working_register_index = op[opdec_pkg::REG_MSB:opdec_pkg::REG_LSB];
        d.pointer_index          = op[0];
        d.port_select            = op[1:0];
        d.call_page = op[opdec_pkg::CALL_PAGE_MSB:opdec_pkg::CALL_PAGE_LSB];
        d.byte_count             = bytes;
        d.cycle_count            = cycles;
        d.legal                  = 1'b1;
        return d;
    endfunction

    // Conditional branch entry, always two bytes and two cycles
    function automatic opdec_pkg::decode_t branch(
        input logic [7:0]              op,
        input opdec_pkg::branch_cond_t cond
    );
        opdec_pkg::decode_t d;
        d = entry(op, opdec_pkg::OP_BRANCH, opdec_pkg::SRC_IMMEDIATE,
                  opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES);
        d.branch_cond = cond;
        return d;
    endfunction

    // Main table; ranges use the high bits, low bits are operand selects
    always_comb begin
        decode_out = entry(opcode_in, opdec_pkg::OP_ILLEGAL,
                           opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE,
                           opdec_pkg::ONE_CYCLE);
        decode_out.legal = 1'b0; // RQ18
        // Register forms (xxxx_1rrr)
        if (opcode_in[3]) begin
            case (opcode_in[7:4])
                4'h6: decode_out = entry(opcode_in, opdec_pkg::OP_ADD, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ1
                4'h7: decode_out = entry(opcode_in, opdec_pkg::OP_ADD_WITH_CARRY, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ1
                4'h5: decode_out = entry(opcode_in, opdec_pkg::OP_LOGICAL_AND_OP, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ4
                4'h4: decode_out = entry(opcode_in, opdec_pkg::OP_LOGICAL_OR_OP, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ4
                4'hd: decode_out = entry(opcode_in, opdec_pkg::OP_EXCLUSIVE_OR_OP, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ4
                4'h1: decode_out = entry(opcode_in, opdec_pkg::OP_INC_OPERAND, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ8
                4'he: begin
                    decode_out = entry(opcode_in, opdec_pkg::OP_DECREMENT_BRANCH_NONZERO, opdec_pkg::SRC_REGISTER, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ9
                    decode_out.branch_cond = opdec_pkg::COND_REG_NONZERO; // RQ9
                end
                4'hf: decode_out = entry(opcode_in, opdec_pkg::OP_MOVE_TO_A, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ11
                4'ha: decode_out = entry(opcode_in, opdec_pkg::OP_MOVE_FROM_A, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ11
                4'hb: decode_out = entry(opcode_in, opdec_pkg::OP_MOVE_IMMEDIATE, opdec_pkg::SRC_REGISTER, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ12
                4'h2: decode_out = entry(opcode_in, opdec_pkg::OP_SWAP_WITH_REGISTER, opdec_pkg::SRC_REGISTER, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ13
                default: ;
            endcase
        end
        // Indirect forms (xxxx_000p)
        else if (opcode_in[3:1] == 3'h0) begin
            case (opcode_in[7:4])
                4'h6: decode_out = entry(opcode_in, opdec_pkg::OP_ADD, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ2
                4'h7: decode_out = entry(opcode_in, opdec_pkg::OP_ADD_WITH_CARRY, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ2
                4'h5: decode_out = entry(opcode_in, opdec_pkg::OP_LOGICAL_AND_OP, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ4
                4'h4: decode_out = entry(opcode_in, opdec_pkg::OP_LOGICAL_OR_OP, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ4
                4'hd: decode_out = entry(opcode_in, opdec_pkg::OP_EXCLUSIVE_OR_OP, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ4
                4'h1: decode_out = entry(opcode_in, opdec_pkg::OP_INC_OPERAND, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ8
                4'hf: decode_out = entry(opcode_in, opdec_pkg::OP_MOVE_TO_A, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ11
                4'ha: decode_out = entry(opcode_in, opdec_pkg::OP_MOVE_FROM_A, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ11
                4'hb: decode_out = entry(opcode_in, opdec_pkg::OP_MOVE_IMMEDIATE, opdec_pkg::SRC_INDIRECT, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ12
                4'h2: decode_out = entry(opcode_in, opdec_pkg::OP_SWAP_WITH_REGISTER, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ13
                4'h3: decode_out = entry(opcode_in, opdec_pkg::OP_SWAP_LOW_NIBBLE, opdec_pkg::SRC_INDIRECT, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ13
                default: ;
            endcase
            // Converter result read sits on the 80 slot
            if (opcode_in == 8'h80) begin
                decode_out = entry(opcode_in, opdec_pkg::OP_CONVERTER_RESULT_READ, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ15
            end
        end
        // Call: page bits on top, low nibble fixed
        else if (opcode_in[3:0] == opdec_pkg::CALL_LOW_NIBBLE && opcode_in[4]) begin
            decode_out = entry(opcode_in, opdec_pkg::OP_CALL, opdec_pkg::SRC_IMMEDIATE, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ20
        end
        // Single-code opcodes
        else begin
            case (opcode_in)
                8'h03: decode_out = entry(opcode_in, opdec_pkg::OP_ADD, opdec_pkg::SRC_IMMEDIATE, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ3
                8'h13: decode_out = entry(opcode_in, opdec_pkg::OP_ADD_WITH_CARRY, opdec_pkg::SRC_IMMEDIATE, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ3
                8'h53: decode_out = entry(opcode_in, opdec_pkg::OP_LOGICAL_AND_OP, opdec_pkg::SRC_IMMEDIATE, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ3
                8'h43: decode_out = entry(opcode_in, opdec_pkg::OP_LOGICAL_OR_OP, opdec_pkg::SRC_IMMEDIATE, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ3
                8'hd3: decode_out = entry(opcode_in, opdec_pkg::OP_EXCLUSIVE_OR_OP, opdec_pkg::SRC_IMMEDIATE, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ3
                8'h17: decode_out = entry(opcode_in, opdec_pkg::OP_INC_A, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'h07: decode_out = entry(opcode_in, opdec_pkg::OP_DEC_A, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'h27: decode_out = entry(opcode_in, opdec_pkg::OP_CLR_A, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'h37: decode_out = entry(opcode_in, opdec_pkg::OP_CPL_A, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'h57: decode_out = entry(opcode_in, opdec_pkg::OP_DECIMAL_ADJUST, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'h47: decode_out = entry(opcode_in, opdec_pkg::OP_NIBBLE_SWAP, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'he7: decode_out = entry(opcode_in, opdec_pkg::OP_ROTATE_LEFT, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'hf7: decode_out = entry(opcode_in, opdec_pkg::OP_ROTATE_LEFT_CARRY, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'h77: decode_out = entry(opcode_in, opdec_pkg::OP_ROTATE_RIGHT, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'h67: decode_out = entry(opcode_in, opdec_pkg::OP_ROTATE_RIGHT_CARRY, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ5
                8'hf6: decode_out = branch(opcode_in, opdec_pkg::COND_CARRY_SET); // RQ10
                8'he6: decode_out = branch(opcode_in, opdec_pkg::COND_CARRY_CLEAR); // RQ10
                8'hc6: decode_out = branch(opcode_in, opdec_pkg::COND_ACC_ZERO); // RQ10
                8'h96: decode_out = branch(opcode_in, opdec_pkg::COND_ACC_NONZERO); // RQ10
                8'h56: decode_out = branch(opcode_in, opdec_pkg::COND_TEST_ONE_HIGH); // RQ10
                8'h46: decode_out = branch(opcode_in, opdec_pkg::COND_TEST_ONE_LOW); // RQ10
                8'h36: decode_out = branch(opcode_in, opdec_pkg::COND_TEST_ZERO_HIGH); // RQ10
                8'h26: decode_out = branch(opcode_in, opdec_pkg::COND_TEST_ZERO_LOW); // RQ10
                8'h16: decode_out = branch(opcode_in, opdec_pkg::COND_TIMER_FLAG); // RQ10
                8'h23: decode_out = entry(opcode_in, opdec_pkg::OP_MOVE_IMMEDIATE, opdec_pkg::SRC_NONE, opdec_pkg::TWO_BYTES, opdec_pkg::TWO_CYCLES); // RQ12
                8'ha3: decode_out = entry(opcode_in, opdec_pkg::OP_PAGE_FETCH, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ14
                8'h85: decode_out = entry(opcode_in, opdec_pkg::OP_SELECT_ANALOG_ZERO, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ15
                8'h95: decode_out = entry(opcode_in, opdec_pkg::OP_SELECT_ANALOG_ONE, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ15
                8'h05: decode_out = entry(opcode_in, opdec_pkg::OP_EXT_INT_ENABLE, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ16
                8'h15: decode_out = entry(opcode_in, opdec_pkg::OP_EXT_INT_DISABLE, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ16
                8'h25: decode_out = entry(opcode_in, opdec_pkg::OP_TIMER_INTERRUPT_ENABLE, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ16
                8'h35: decode_out = entry(opcode_in, opdec_pkg::OP_TIMER_INTERRUPT_DISABLE, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::ONE_CYCLE); // RQ16
                8'h93: decode_out = entry(opcode_in, opdec_pkg::OP_INTERRUPT_EXIT, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ17
                8'h83: decode_out = entry(opcode_in, opdec_pkg::OP_SUBROUTINE_EXIT, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ17
                // Everything else, deleted full-family codes included, stays illegal
                default: ; // RQ18
            endcase
        end
        // Expander codes share the 1xxx pattern, so they override last
        if (opcode_in[3:2] == 2'h3) begin
            case (opcode_in[7:4])
                4'h0: decode_out = entry(opcode_in, opdec_pkg::OP_EXPANDER_READ, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ6
                4'h3: decode_out = entry(opcode_in, opdec_pkg::OP_EXPANDER_WRITE, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ6
                4'h9: decode_out = entry(opcode_in, opdec_pkg::OP_EXPANDER_AND, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ7
                4'h8: decode_out = entry(opcode_in, opdec_pkg::OP_EXPANDER_OR, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ7
                default: ;
            endcase
        end
        // Port zero codes sit in the register and indirect patterns
        if (opcode_in == 8'h08)
            decode_out = entry(opcode_in, opdec_pkg::OP_PORT_INPUT, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ19
        if (opcode_in == 8'h90)
            decode_out = entry(opcode_in, opdec_pkg::OP_PORT_OUTPUT, opdec_pkg::SRC_NONE, opdec_pkg::ONE_BYTE, opdec_pkg::TWO_CYCLES); // RQ19
    end

endmodule
`default_nettype wire

// ==== verilog/reduced_opcode_decoder.sv ====
// Top of the opcode decoder: fetch handshake, hold and registered decode
//
// Behaviour
// RQ1: 68-6F add reg, 78-7F add with carry
// RQ2: 60-61, 70-71 indirect adds, bit0 pointer
// RQ3: Immediate accumulator ops, two bytes, two cycles
// RQ4: Register and indirect logic operation codes
// RQ5: Single-byte accumulator ops, one cycle each
// RQ6: Expander read/write, two cycles, ports 4-7
// RQ7: Expander and/or, one byte, two cycles
// RQ8: Increment register or indirect memory, one cycle
// RQ9: E8-EF decrement and branch if nonzero
// RQ10: Conditional branches, two bytes, two cycles
// RQ11: One-cycle moves to and from accumulator
// RQ12: Immediate moves, two bytes, two cycles
// RQ13: Exchanges with register, memory, low nibble
// RQ14: A3 in-page fetch, one byte, two cycles
// RQ15: 80 converter read; 85/95 analog selects
// RQ16: Interrupt enable/disable controls, one cycle
// RQ17: 93 interrupt exit, 83 subroutine exit
// RQ18: Deleted full-family opcodes are flagged illegal
// RQ19: Port zero input and output replace bus port
// RQ20: Call carries page bits in opcode top
// RQ21: Two-cycle opcodes hold fetch for second cycle
`timescale 1ns/1ns
`default_nettype none
module reduced_opcode_decoder (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    // Opcode byte from program memory
    input  wire logic [7:0]         opcode_in,
    input  wire logic               opcode_valid_in,
    // Decode to the datapath
    output opdec_pkg::decode_t      decode_out,
    output logic                    decode_valid_out,
    output logic                    second_cycle_out,
    output logic                    illegal_out,
    output logic                    fetch_ready_out
);

    // Sequencer states
    typedef enum logic [0:0] {
        ST_FIRST,
        ST_SECOND
    } seq_state_t;

    seq_state_t         state;
    seq_state_t         next_state;
    opdec_pkg::decode_t table_decode;
    opdec_pkg::decode_t next_decode;
    opdec_pkg::decode_t decode;
    logic               next_decode_valid;
    logic               decode_valid;
    logic               next_second_cycle;
    logic               second_cycle;
    logic               next_illegal;
    logic               illegal;
    logic               next_fetch_ready;
    logic               fetch_ready;

    // True when the entry needs a second machine cycle
    function automatic logic needs_two(input opdec_pkg::decode_t d);
        return d.legal && (d.cycle_count == opdec_pkg::TWO_CYCLES);
    endfunction

    opcode_table table_inst (
        .opcode_in  (opcode_in),
        .decode_out (table_decode)
    );

    // Next state: a two-cycle opcode parks the fetch for one cycle
    always_comb begin
        next_state        = state;
        next_decode       = decode;
        next_decode_valid = 1'b0;
        next_second_cycle = 1'b0;
        next_illegal      = 1'b0;
        next_fetch_ready  = 1'b1;
        case (state)
            ST_FIRST: begin
                if (opcode_valid_in) begin
                    next_decode       = table_decode;
                    next_decode_valid = 1'b1;
                    next_illegal      = !table_decode.legal; // RQ18
                    if (needs_two(table_decode)) begin
                        next_state       = ST_SECOND; // RQ21
                        next_fetch_ready = 1'b0; // RQ21
                    end
                end
            end
            ST_SECOND: begin
                // Decode stays, fetch resumes after this cycle
                next_second_cycle = 1'b1; // RQ21
                next_state        = ST_FIRST;
            end
            default: begin
                next_state = ST_FIRST;
            end
        endcase
    end

    // Registered state; reset leaves an idle, illegal-free decode
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state        <= ST_FIRST;
            decode       <= '0;
            decode_valid <= 1'b0;
            second_cycle <= 1'b0;
            illegal      <= 1'b0;
            fetch_ready  <= 1'b1;
        end else begin
            state        <= next_state;
            decode       <= next_decode;
            decode_valid <= next_decode_valid;
            second_cycle <= next_second_cycle;
            illegal      <= next_illegal;
            fetch_ready  <= next_fetch_ready;
        end
    end

    // Outputs come straight from flip-flops
    assign decode_out       = decode;
    assign decode_valid_out = decode_valid;
    assign second_cycle_out = second_cycle;
    assign illegal_out      = illegal;
    assign fetch_ready_out  = fetch_ready;

endmodule
`default_nettype wire

// ==== testbench/opdec_asserts.sv ====
// Checker: handshake timing and opcode fields at the decoder ports
`timescale 1ns/1ns
`default_nettype none
module opdec_asserts (
    // Clock, reset and fetch side
    input wire logic               clk_in, reset_n_in, opcode_valid_in,
    input wire logic [7:0]         opcode_in,
    // Decode side
    input wire opdec_pkg::decode_t decode_out,
    input wire logic               decode_valid_out, second_cycle_out,
    input wire logic               illegal_out, fetch_ready_out
);
    // Legal two-cycle decode, the only kind that holds the fetch
    wire logic two_cyc = decode_out.legal && decode_out.cycle_count == 2'h2;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    take_answer_a: assert property (
        opcode_valid_in && fetch_ready_out |=> decode_valid_out)
        else $error("taken opcode not answered");
    refuse_hold_a: assert property (
        !fetch_ready_out |=> !decode_valid_out)
        else $error("opcode taken while held");
    second_cycle_a: assert property (
        decode_valid_out && two_cyc |-> !fetch_ready_out ##1
        second_cycle_out && fetch_ready_out) else $error("bad second cycle");
    one_cycle_a: assert property (
        decode_valid_out && !two_cyc |-> fetch_ready_out ##1 !second_cycle_out)
        else $error("one-cycle decode held the fetch");
    illegal_flag_a: assert property (
        illegal_out || decode_valid_out |->
        decode_valid_out && illegal_out != decode_out.legal)
        else $error("illegal flag wrong");
    reg_field_a: assert property (
        decode_valid_out |-> decode_out.working_register_index ==
        $past(opcode_in[2:0]) && decode_out.pointer_index == $past(opcode_in[0]))
        else $error("register field wrong");
    port_field_a: assert property (
        decode_valid_out |-> decode_out.port_select == $past(opcode_in[1:0]))
        else $error("port field wrong");
    call_page_a: assert property (
        decode_valid_out && decode_out.op_class == opdec_pkg::OP_CALL |->
        decode_out.call_page == $past(opcode_in[7:5])) else $error("bad page");
    // Main scenarios reached
    cover property (decode_valid_out && illegal_out);
    cover property (second_cycle_out && opcode_valid_in);
    cover property (decode_valid_out && decode_out.op_class == opdec_pkg::OP_CALL);
endmodule
bind reduced_opcode_decoder opdec_asserts opdec_asserts_inst (.clk_in,
    .reset_n_in, .opcode_valid_in, .opcode_in, .decode_out,
    .decode_valid_out, .second_cycle_out, .illegal_out, .fetch_ready_out);
`default_nettype wire

// ==== testbench/prog_mem_model.sv ====
// Program memory model: offers opcode bytes, holds them until taken
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
    // Clock, reset and bench request
    input  wire logic       clk_in, reset_n_in, send_in, fetch_ready_in,
    input  wire logic [7:0] byte_in,
    // Opcode lines to the decoder
    output logic [7:0]      opcode_out,
    output logic            valid_out
);
    // Hold while refused; idle lines toggle so a stale byte never decodes
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            opcode_out <= 8'h00;
            valid_out  <= 1'b0;
        end else if (!valid_out || fetch_ready_in) begin
            opcode_out <= send_in ? byte_in : ~opcode_out;
            valid_out  <= send_in;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Bench: opcode sweep, back-to-back fetches and mid-run reset
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // Opcode, then timing: 1 one byte one cycle, 2 one byte two, 3 two, 0 bad
    localparam logic [971:0] TBL = {
        108'h681_6f1_781_7f1_601_711_033_133_533,
        108'h433_d33_581_481_df1_501_411_d01_171,
        108'h071_271_371_571_471_e71_f71_771_671,
        108'h0c2_3f2_9d2_8e2_181_101_ef3_f63_e63,
        108'hc63_963_563_463_363_263_163_f81_f01,
        108'haf1_a11_233_b83_b13_2b1_201_311_a32,
        108'h802_851_951_051_151_251_351_932_832,
        108'h082_902_143_f43_c50_e50_c70_d70_c80,
        108'he30_a50_b60_760_120_750_990_880_020};
    logic               clk_in = 1'b0, reset_n_in = 1'b0, send = 1'b0;
    logic [7:0]         byte_val = 8'h00, opcode_in;
    logic               opcode_valid_in, decode_valid_out, second_cycle_out;
    logic               illegal_out, fetch_ready_out;
    opdec_pkg::decode_t decode_out;
    int                 n_mismatch = 0, compares = 0;
    always #5 clk_in = ~clk_in;
    prog_mem_model prog_mem_model_inst (.clk_in, .reset_n_in, .send_in(send),
        .byte_in(byte_val), .fetch_ready_in(fetch_ready_out),
        .opcode_out(opcode_in), .valid_out(opcode_valid_in));
    reduced_opcode_decoder reduced_opcode_decoder_inst (.clk_in, .reset_n_in,
        .opcode_in, .opcode_valid_in, .decode_out, .decode_valid_out,
        .second_cycle_out, .illegal_out, .fetch_ready_out);
    task automatic chk(input string n, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Request stays up until the caller's next edge
    task automatic put(input logic [7:0] op);
        @(posedge clk_in);
        send     <= 1'b1;
        byte_val <= op;
    endtask
    task automatic stop_send;
        @(posedge clk_in);
        send <= 1'b0;
    endtask
    // Bounded wait for one decode, then counts, handshake and class
    task automatic wait_dec(input logic [11:0] e, opdec_pkg::op_class_t c);
        int k;
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (decode_valid_out !== 1'b1 && k < 8);
        chk("decode_valid", 8'(decode_valid_out), 8'h01);
        chk("illegal", 8'(illegal_out), 8'(e[3:0] == 4'h0));
        if (e[3:0] != 4'h0) begin
            chk("bytes", 8'(decode_out.byte_count),
                8'(e[3:0] == 4'h3) + 8'h01);
            chk("cycles", 8'(decode_out.cycle_count),
                8'(e[3:0] > 4'h1) + 8'h01);
        end
        chk("fetch_ready", 8'(fetch_ready_out), 8'(e[3:0] < 4'h2));
        if (e[3:0] > 4'h1) begin
            @(negedge clk_in);
            chk("second_cycle", 8'(second_cycle_out), 8'h01);
        end
        if (c != opdec_pkg::OP_ILLEGAL)
            chk("class", 8'(decode_out.op_class), 8'(c));
    endtask
    task automatic run_op(input logic [11:0] e, opdec_pkg::op_class_t c);
        put(e[11:4]);
        stop_send;
        wait_dec(e, c);
    endtask
    task automatic sc_sweep;
        for (int i = 0; i < 81; i++)
            run_op(TBL[971 - 12 * i -: 12], opdec_pkg::OP_ILLEGAL);
    endtask
    // Second opcode offered during the hold, then a call right behind
    task automatic sc_back;
        put(8'h03);
        put(8'h6f);
        stop_send;
        wait_dec(12'h033, opdec_pkg::OP_ADD);
        chk("src", 8'(decode_out.operand_src), 8'(opdec_pkg::SRC_IMMEDIATE));
        wait_dec(12'h6f1, opdec_pkg::OP_ADD);
        put(8'h78);
        put(8'h34);
        stop_send;
        wait_dec(12'h781, opdec_pkg::OP_ADD_WITH_CARRY);
        wait_dec(12'h343, opdec_pkg::OP_CALL);
        chk("call_page", 8'(decode_out.call_page), 8'h01);
    endtask
    // Reset lands on a two-cycle decode; the next fetch must start clean
    task automatic sc_reset;
        put(8'h23);
        stop_send;
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        @(negedge clk_in);
        chk("fetch_ready", 8'(fetch_ready_out), 8'h01);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        run_op(12'h051, opdec_pkg::OP_EXT_INT_ENABLE);
    endtask
    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        sc_sweep;
        sc_back;
        sc_reset;
        end_sim;
    end
    // About 90 decodes of three or four cycles each; six times that is a hang
    initial begin
        #20000;
        n_mismatch++;
        end_sim;
    end
endmodule
`default_nettype wire
